/* File: src/processor_identify_query_responder.sv */
// top of the processor identification responder with its register port
// assumes the requester and the register master run on i_clk_sys
//
// Overview of operation
// - leaf zero gives highest standard leaf seven and the vendor string
// - leaf one second word: only the logical count field reads one
// - leaf one feature word sets bits 0,1,3,4,5,6,8,9,13,31
// - leaf two gives one, then three zero words
// - standard 0-0bh, extended from 8000_0000h; unlisted ones all zero
// - leaf seven sub-leaf zero: count one, bit 7 per protection support
// - extended base leaf reports highest extended leaf 8000_0008h
// - extended leaf one bit 20 set only while execute-disable control clear
// - extended leaf eight reports 32-bit physical and linear widths
//
// Chosen here: the placing of the registers and the plain strobed port.
`default_nettype none
`include "processor_identify_query_resp_defs.svh"

module ident_responder
  import ident_resp_pkg::*;
#(
  parameter logic [31:0] VENDOR_B = 32'h1111_1111, // arbitrary value
  parameter logic [31:0] VENDOR_C = 32'h2222_2222, // arbitrary value
  parameter logic [31:0] VENDOR_D = 32'h3333_3333, // arbitrary value
  parameter logic [31:0] SIGNATURE = 32'h0000_0a10 // arbitrary value
)
(
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  input wire logic i_query_valid,
  input wire logic [31:0] i_leaf,
  input wire logic [31:0] i_subleaf,
  input wire logic i_no_execute_disable_off,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  output logic o_result_valid,
  output logic [31:0] o_eax,
  output logic [31:0] o_ebx,
  output logic [31:0] o_ecx,
  output logic [31:0] o_edx
);

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  leaf_query_if q ();

  logic [31:0] ctrl;
  logic [31:0] next_ctrl;
  logic vendor_seen;
  logic next_vendor_seen;
  logic order_err;
  logic next_order_err;
  leaf_class_t last_class;
  leaf_class_t next_last_class;
  logic [31:0] last_leaf;
  logic [31:0] next_last_leaf;
  logic [31:0] query_count;
  logic [31:0] next_query_count;
  logic [31:0] next_rdata;
  result_t result;
  result_t next_result;
  logic next_result_valid;
  leaf_class_t query_class;
  result_t lookup;
  logic [31:0] status_word;

  // ----------------------------------------
  // register decode
  // ----------------------------------------
  // one write decode for every register keeps the map in one place
  function automatic logic write_hit(
    input logic wr,
    input logic [7:0] addr,
    input logic [7:0] target
  );
    return wr && (addr == target);
  endfunction : write_hit

  // ----------------------------------------
  // leaf tables
  // ----------------------------------------
  // the tables see the raw query inputs: they come from core logic on
  // this clock, so no synchroniser is needed and none would be wanted
  assign q.leaf = i_leaf;
  assign q.subleaf = i_subleaf;
  assign q.no_execute_disable_off = i_no_execute_disable_off;
  assign q.supervisor_exec_protect = ctrl[`CTRL_EXEC_PROTECT_BIT];

  std_leaf_table #(
    .VENDOR_B(VENDOR_B),
    .VENDOR_C(VENDOR_C),
    .VENDOR_D(VENDOR_D),
    .SIGNATURE(SIGNATURE)
  ) u_std (
    .q(q.std_table)
  );

  ext_leaf_table u_ext (
    .q(q.ext_table)
  );

  // ----------------------------------------
  // leaf dispatch
  // ----------------------------------------
  // the class picks one table; the other table's answer goes unused
  always_comb
  begin
    query_class = classify(i_leaf);
    unique case (query_class)
      CLASS_STD:
      begin
        lookup = q.std_res;
      end
      CLASS_EXT:
      begin
        lookup = q.ext_res;
      end
      default:
      begin
        lookup = '0;
      end
    endcase
  end

  // ----------------------------------------
  // result registers
  // ----------------------------------------
  // one cycle of latency buys flop-driven outputs; results hold until
  // the next query so the core may sample them late
  always_comb
  begin
    next_result = result;
    next_result_valid = 1'b0;
    if (i_query_valid)
    begin
      next_result = lookup;
      next_result_valid = 1'b1;
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      result <= '0;
      o_result_valid <= 1'b0;
    end
    else
    begin
      result <= next_result;
      o_result_valid <= next_result_valid;
    end
  end

  // ----------------------------------------
  // result words
  // ----------------------------------------
  // words hold between queries; only the valid pulse drops back
  assign o_eax = result.eax;
  assign o_ebx = result.ebx;
  assign o_ecx = result.ecx;
  assign o_edx = result.edx;

  // ----------------------------------------
  // query tracking
  // ----------------------------------------
  // order_err flags a requester that skipped the vendor check; it only
  // observes, the answer itself is never withheld
  always_comb
  begin
    next_vendor_seen = vendor_seen;
    next_order_err = order_err;
    next_last_leaf = last_leaf;
    next_last_class = last_class;
    next_query_count = query_count;
    if (write_hit(i_wr, i_addr, `REG_STATUS))
    begin
      if (i_wdata[`STAT_VENDOR_BIT])
      begin
        next_vendor_seen = 1'b0;
      end
      if (i_wdata[`STAT_ORDER_BIT])
      begin
        next_order_err = 1'b0;
      end
    end
    if (write_hit(i_wr, i_addr, `REG_QUERY_COUNT))
    begin
      next_query_count = 32'h0000_0000;
    end
    // a query in the clearing cycle still sets its flags
    // the count wraps silently; software reads it as a running tally
    if (i_query_valid)
    begin
      next_last_leaf = i_leaf;
      next_last_class = query_class;
      next_query_count = query_count + 32'h0000_0001;
      if (i_leaf == `LEAF_VENDOR)
      begin
        next_vendor_seen = 1'b1;
      end
      else if (!vendor_seen)
      begin
        next_order_err = 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      vendor_seen <= 1'b0;
      order_err <= 1'b0;
      last_leaf <= 32'h0000_0000;
      last_class <= CLASS_NONE;
      query_count <= 32'h0000_0000;
    end
    else
    begin
      vendor_seen <= next_vendor_seen;
      order_err <= next_order_err;
      last_leaf <= next_last_leaf;
      last_class <= next_last_class;
      query_count <= next_query_count;
    end
  end

  // ----------------------------------------
  // status word
  // ----------------------------------------
  // both flags are write-one-to-clear so software never wipes a fresh set
  always_comb
  begin
    status_word = 32'h0000_0000;
    status_word[`STAT_VENDOR_BIT] = vendor_seen;
    status_word[`STAT_ORDER_BIT] = order_err;
    status_word[`STAT_CLASS_LSB +: 2] = last_class;
  end

  // ----------------------------------------
  // register port
  // ----------------------------------------
  // ctrl keeps only the protection support bit; the rest reads zero
  always_comb
  begin
    next_ctrl = ctrl;
    if (write_hit(i_wr, i_addr, `REG_CTRL))
    begin
      next_ctrl = 32'h0000_0000;
      next_ctrl[`CTRL_EXEC_PROTECT_BIT] = i_wdata[`CTRL_EXEC_PROTECT_BIT];
    end
  end

  // unmapped reads return zero; read data lasts one cycle only
  always_comb
  begin
    next_rdata = 32'h0000_0000;
    if (i_rd)
    begin
      case (i_addr)
        `REG_CTRL:
        begin
          next_rdata = ctrl;
        end
        `REG_STATUS:
        begin
          next_rdata = status_word;
        end
        `REG_LAST_LEAF:
        begin
          next_rdata = last_leaf;
        end
        `REG_QUERY_COUNT:
        begin
          next_rdata = query_count;
        end
        default:
        begin
          next_rdata = 32'h0000_0000;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      ctrl <= `CTRL_RESET;
      o_rdata <= 32'h0000_0000;
    end
    else
    begin
      ctrl <= next_ctrl;
      o_rdata <= next_rdata;
    end
  end

endmodule : ident_responder
`default_nettype wire

/* File: include/processor_identify_query_resp_defs.svh */
// constants of the identification responder: leaves, words, fields, offsets
// assumes inclusion by bare name from the package and every design module
`ifndef IDENT_RESP_DEFS_SVH
`define IDENT_RESP_DEFS_SVH

// ----------------------------------------
// leaf numbers
// ----------------------------------------
`define LEAF_VENDOR 32'h0000_0000
`define LEAF_SIGNATURE 32'h0000_0001
`define LEAF_CACHE 32'h0000_0002
`define LEAF_EXT_FEAT 32'h0000_0007
`define LEAF_STD_LAST 32'h0000_000b
`define LEAF_EXT_BASE 32'h8000_0000
`define LEAF_EXT_INFO 32'h8000_0001
`define LEAF_ADDR_SIZE 32'h8000_0008

// ----------------------------------------
// returned values and field positions
// ----------------------------------------
`define MAX_STD_LEAF 32'h0000_0007
`define MAX_EXT_LEAF 32'h8000_0008
`define FEATURE_WORD 32'h8000_237b
`define LOGICAL_COUNT 8'h01
`define COUNT_LSB 16
`define CACHE_ITER 32'h0000_0001
`define LEAF7_SUBLEAF_CNT 32'h0000_0001
`define SUPERVISOR_EXEC_PROTECT_BIT 7
`define NO_EXECUTE_DISABLE_BIT 20
`define ADDR_WIDTH_BITS 8'h20
`define LIN_ADDR_LSB 8

// ----------------------------------------
// register port map
// ----------------------------------------
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_LAST_LEAF 8'h08
`define REG_QUERY_COUNT 8'h0c
`define CTRL_EXEC_PROTECT_BIT 0
`define CTRL_RESET 32'h0000_0001
`define STAT_VENDOR_BIT 0
`define STAT_ORDER_BIT 1
`define STAT_CLASS_LSB 2

`endif

/* File: include/processor_identify_query_resp_pkg.sv */
// types and leaf classification shared by the responder modules
// assumes the constants header is on the include path
`default_nettype none
`include "processor_identify_query_resp_defs.svh"

package ident_resp_pkg;

  typedef struct packed {
    logic [31:0] eax;
    logic [31:0] ebx;
    logic [31:0] ecx;
    logic [31:0] edx;
  } result_t;

  typedef enum logic [1:0] {
    CLASS_NONE,
    CLASS_STD,
    CLASS_EXT
  } leaf_class_t;

  function automatic leaf_class_t classify(input logic [31:0] leaf);
    if (leaf <= `LEAF_STD_LAST)
      return CLASS_STD;
    else if (leaf >= `LEAF_EXT_BASE)
      return CLASS_EXT;
    else
      return CLASS_NONE;
  endfunction : classify

endpackage : ident_resp_pkg
`default_nettype wire

/* File: include/leaf_query_if.sv */
// carrier between the responder top and its two leaf tables
// assumes all three sit on one clock; the tables are pure logic
`default_nettype none

interface leaf_query_if;
  import ident_resp_pkg::*;
  logic [31:0] leaf;
  logic [31:0] subleaf;
  logic no_execute_disable_off;
  logic supervisor_exec_protect;
  result_t std_res;
  result_t ext_res;

  modport requester (
    output leaf, subleaf, no_execute_disable_off, supervisor_exec_protect,
    input std_res, ext_res
  );
  modport std_table (
    input leaf, subleaf, supervisor_exec_protect,
    output std_res
  );
  modport ext_table (
    input leaf, no_execute_disable_off,
    output ext_res
  );
endinterface : leaf_query_if
`default_nettype wire

/* File: src/std_leaf_table.sv */
// lookup of the standard leaves
// assumes leaf and sub-leaf are stable in the cycle they are looked up
`default_nettype none
`include "processor_identify_query_resp_defs.svh"

module std_leaf_table
  import ident_resp_pkg::*;
#(
  parameter logic [31:0] VENDOR_B = 32'h1111_1111, // arbitrary value
  parameter logic [31:0] VENDOR_C = 32'h2222_2222, // arbitrary value
  parameter logic [31:0] VENDOR_D = 32'h3333_3333, // arbitrary value
  parameter logic [31:0] SIGNATURE = 32'h0000_0a10 // arbitrary value
)
(
  leaf_query_if.std_table q
);

  always_comb
  begin
    q.std_res = '0;
    case (q.leaf)
      `LEAF_VENDOR:
      begin
        q.std_res.eax = `MAX_STD_LEAF;
        q.std_res.ebx = VENDOR_B;
        q.std_res.ecx = VENDOR_C;
        q.std_res.edx = VENDOR_D;
      end
      `LEAF_SIGNATURE:
      begin
        q.std_res.eax = SIGNATURE;
        q.std_res.ebx[`COUNT_LSB +: 8] = `LOGICAL_COUNT;
        q.std_res.edx = `FEATURE_WORD;
      end
      `LEAF_CACHE:
      begin
        q.std_res.eax = `CACHE_ITER;
      end
      `LEAF_EXT_FEAT:
      begin
        if (q.subleaf == 32'h0000_0000)
        begin
          q.std_res.eax = `LEAF7_SUBLEAF_CNT;
          q.std_res.ebx[`SUPERVISOR_EXEC_PROTECT_BIT] = q.supervisor_exec_protect;
        end
      end
      default:
      begin
        q.std_res = '0;
      end
    endcase
  end

endmodule : std_leaf_table
`default_nettype wire

/* File: src/ext_leaf_table.sv */
// lookup of the extended leaves
// assumes the execute-disable control level comes from the same clock domain
`default_nettype none
`include "processor_identify_query_resp_defs.svh"

module ext_leaf_table
  import ident_resp_pkg::*;
(
  leaf_query_if.ext_table q
);

  always_comb
  begin
    q.ext_res = '0;
    case (q.leaf)
      `LEAF_EXT_BASE:
      begin
        q.ext_res.eax = `MAX_EXT_LEAF;
      end
      `LEAF_EXT_INFO:
      begin
        q.ext_res.edx[`NO_EXECUTE_DISABLE_BIT] = ~q.no_execute_disable_off;
      end
      `LEAF_ADDR_SIZE:
      begin
        q.ext_res.eax[7:0] = `ADDR_WIDTH_BITS;
        q.ext_res.eax[`LIN_ADDR_LSB +: 8] = `ADDR_WIDTH_BITS;
      end
      default:
      begin
        q.ext_res = '0;
      end
    endcase
  end

endmodule : ext_leaf_table
`default_nettype wire

/* File: verif/processor_identify_query_resp_assertions.sv */
// checker of the identification responder result port
// assumes it is bound into the responder top on one clock
`default_nettype none

module ident_resp_checker #(
  parameter logic [31:0] VENDOR_B = 32'h0,
  parameter logic [31:0] VENDOR_C = 32'h0,
  parameter logic [31:0] VENDOR_D = 32'h0,
  parameter logic [31:0] SIGNATURE = 32'h0
)
(
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  input wire logic i_query_valid,
  input wire logic [31:0] i_leaf,
  input wire logic [31:0] i_subleaf,
  input wire logic i_no_execute_disable_off,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic o_result_valid,
  input wire logic [31:0] o_eax,
  input wire logic [31:0] o_ebx,
  input wire logic [31:0] o_ecx,
  input wire logic [31:0] o_edx
);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  timeunit 1ns;
  timeprecision 1ns;
  logic [127:0] w;
  logic zl;
  logic protect_q;
  assign w = {o_eax, o_ebx, o_ecx, o_edx};
  assign zl = (i_leaf >= 32'h3 && i_leaf <= 32'h6) || (i_leaf >= 32'h8 && i_leaf < 32'h8000_0000)
    || (i_leaf >= 32'h8000_0002 && i_leaf <= 32'h8000_0007) || i_leaf > 32'h8000_0008;
  // shadow of the protection support bit, so leaf seven can be judged
  always_ff @(posedge i_clk_sys or posedge i_sys_rst)
    if (i_sys_rst)
      protect_q <= 1'b1;
    else if (i_wr && i_addr == 8'h00)
      protect_q <= i_wdata[0];

  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_sys_rst);

  a_valid_next: assert property (i_query_valid |=> o_result_valid)
    else $error("no result after query");
  a_valid_cause: assert property (o_result_valid |-> $past(i_query_valid))
    else $error("result without query");
  a_vendor_words: assert property (
    i_query_valid && i_leaf == 32'h0 |=> w == {32'h7, VENDOR_B, VENDOR_C, VENDOR_D})
    else $error("leaf zero words wrong");
  a_signature_words: assert property (
    i_query_valid && i_leaf == 32'h1 |=> w == {SIGNATURE, 32'h0001_0000, 32'h0, 32'h8000_237b})
    else $error("leaf one words wrong");
  a_cache_words: assert property (
    i_query_valid && i_leaf == 32'h2 |=> w == {32'h1, 96'h0})
    else $error("leaf two words wrong");
  a_zero_leaves: assert property (i_query_valid && zl |=> w == 128'h0)
    else $error("empty leaf not zero");
  a_leaf7_sub0: assert property (
    i_query_valid && i_leaf == 32'h7 && i_subleaf == 32'h0
    |=> w == {32'h1, 24'h0, $past(protect_q), 7'h0, 64'h0})
    else $error("leaf seven words wrong");
  a_leaf7_subnz: assert property (
    i_query_valid && i_leaf == 32'h7 && i_subleaf != 32'h0 |=> w == 128'h0)
    else $error("leaf seven sub-leaf not zero");
  a_ext_base: assert property (
    i_query_valid && i_leaf == 32'h8000_0000 |=> w == {32'h8000_0008, 96'h0})
    else $error("extended base words wrong");
  a_exec_disable_bit: assert property (
    i_query_valid && i_leaf == 32'h8000_0001
    |=> w == {96'h0, 11'h0, !$past(i_no_execute_disable_off), 20'h0})
    else $error("execute-disable bit wrong");
  a_addr_width: assert property (
    i_query_valid && i_leaf == 32'h8000_0008 |=> w == {32'h0000_2020, 96'h0})
    else $error("address widths wrong");
  a_words_hold: assert property (!i_query_valid |=> $stable(w))
    else $error("words moved without query");
endmodule : ident_resp_checker

bind ident_responder ident_resp_checker #(.VENDOR_B(VENDOR_B), .VENDOR_C(VENDOR_C),
  .VENDOR_D(VENDOR_D), .SIGNATURE(SIGNATURE)) u_chk (
  .i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst), .i_query_valid(i_query_valid),
  .i_leaf(i_leaf), .i_subleaf(i_subleaf),
  .i_no_execute_disable_off(i_no_execute_disable_off), .i_addr(i_addr),
  .i_wdata(i_wdata), .i_wr(i_wr), .o_result_valid(o_result_valid), .o_eax(o_eax),
  .o_ebx(o_ebx), .o_ecx(o_ecx), .o_edx(o_edx)
);
`default_nettype wire

/* File: verif/core_query_model.sv */
// model of the core that issues identification queries
// assumes answers come one cycle after each taken query
`default_nettype none

module core_query_model #(
  parameter logic [31:0] VENDOR_B = 32'h0,
  parameter logic [31:0] VENDOR_C = 32'h0,
  parameter logic [31:0] VENDOR_D = 32'h0
)
(
  input wire logic i_clk_sys,
  input wire logic i_result_valid,
  input wire logic [127:0] i_words,
  output logic o_query_valid,
  output logic [31:0] o_leaf,
  output logic [31:0] o_subleaf
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [127:0] res = 128'h0;
  logic [31:0] pend = 32'h0;
  logic vendor_ok = 1'b0;
  int answers = 0;

  initial
  begin
    o_query_valid = 1'b0;
    o_leaf = 32'h0;
    o_subleaf = 32'h0;
  end

  always @(posedge i_clk_sys)
  begin
    pend <= o_leaf;
    if (i_result_valid)
    begin
      res <= i_words;
      answers <= answers + 1;
      // vendor_ok records whether the leaf zero answer matched the vendor string
      if (pend == 32'h0)
        vendor_ok <= (i_words[95:0] == {VENDOR_B, VENDOR_C, VENDOR_D});
    end
  end

  // called at a rising edge; back to back calls give back to back queries
  task automatic ask(input logic [31:0] leaf, input logic [31:0] sub);
    o_query_valid <= 1'b1;
    o_leaf <= leaf;
    o_subleaf <= sub;
    @(posedge i_clk_sys);
  endtask : ask

  task automatic settle();
    o_query_valid <= 1'b0;
    repeat (2) @(posedge i_clk_sys);
  endtask : settle
endmodule : core_query_model
`default_nettype wire

/* File: verif/testbench.sv */
// self-checking bench of the identification responder
// assumes the responder top, its checker and the core model
`default_nettype none

module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [31:0] VB = 32'h1a2b_3c4d; // arbitrary value
  localparam logic [31:0] VC = 32'h5e6f_7081; // arbitrary value
  localparam logic [31:0] VD = 32'h92a3_b4c5; // arbitrary value
  localparam logic [31:0] SG = 32'h0000_0c21; // arbitrary value
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic noexec_off = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic qv, rv;
  logic [31:0] leaf, sub, rdata, eax, ebx, ecx, edx;
  int failures = 0;
  int tests_run = 0;
  int base;
  logic [31:0] zl [10] = '{32'h3, 32'h6, 32'h8, 32'hb, 32'hc, 32'h7fff_ffff,
    32'h8000_0002, 32'h8000_0007, 32'h8000_0009, 32'hffff_ffff};

  ident_responder #(.VENDOR_B(VB), .VENDOR_C(VC), .VENDOR_D(VD), .SIGNATURE(SG)) dut (
    .i_clk_sys(clk), .i_sys_rst(rst), .i_query_valid(qv), .i_leaf(leaf), .i_subleaf(sub),
    .i_no_execute_disable_off(noexec_off), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
    .i_rd(rd),
    .o_rdata(rdata), .o_result_valid(rv), .o_eax(eax), .o_ebx(ebx), .o_ecx(ecx), .o_edx(edx)
  );
  core_query_model #(.VENDOR_B(VB), .VENDOR_C(VC), .VENDOR_D(VD)) u_core (
    .i_clk_sys(clk), .i_result_valid(rv), .i_words({eax, ebx, ecx, edx}),
    .o_query_valid(qv), .o_leaf(leaf), .o_subleaf(sub)
  );

  initial
  begin
    forever #5 clk = ~clk;
  end

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask : wr_reg

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 check(rdata, exp);
    @(posedge clk);
  endtask : rd_chk

  task automatic q(input logic [31:0] l, input logic [31:0] s, input logic [127:0] exp);
    u_core.ask(l, s);
    u_core.settle();
    for (int i = 0; i < 4; i++)
      check(u_core.res[127 - 32 * i -: 32], exp[127 - 32 * i -: 32]);
    $display("query %h done", l);
  endtask : q

  task automatic report_and_stop();
    $display("checks %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : report_and_stop

  initial
  begin
    repeat (5000) @(posedge clk);
    failures++;
    report_and_stop();
  end

  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial
  begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd_chk(8'h00, 32'h1);
    rd_chk(8'h0c, 32'h0);
    q(32'h0, 32'h0, {32'h7, VB, VC, VD});
    check({31'h0, u_core.vendor_ok}, 32'h1);
    rd_chk(8'h04, 32'h0000_0005);
    q(32'h1, 32'h0, {SG, 32'h0001_0000, 32'h0, 32'h8000_237b});
    q(32'h2, 32'h3, {32'h1, 96'h0});
    foreach (zl[i])
      q(zl[i], 32'h0, 128'h0);
    q(32'h7, 32'h0, {32'h1, 32'h80, 64'h0});
    q(32'h7, 32'h5, 128'h0);
    wr_reg(8'h00, 32'h0);
    q(32'h7, 32'h0, {32'h1, 96'h0});
    q(32'h8000_0000, 32'h0, {32'h8000_0008, 96'h0});
    noexec_off <= 1'b1;
    q(32'h8000_0001, 32'h0, 128'h0);
    noexec_off <= 1'b0;
    q(32'h8000_0001, 32'h0, {96'h0, 32'h0010_0000});
    base = u_core.answers;
    u_core.ask(32'h2, 32'h0);
    u_core.ask(32'h8000_0008, 32'h0);
    u_core.settle();
    check(u_core.answers - base, 32'h2);
    check(u_core.res[127:96], 32'h0000_2020);
    repeat (3) @(posedge clk);
    check(eax, 32'h0000_2020);
    rd_chk(8'h08, 32'h8000_0008);
    rd_chk(8'h0c, u_core.answers);
    wr_reg(8'h0c, 32'h0);
    rd_chk(8'h0c, 32'h0);
    wr_reg(8'h10, 32'hffff_ffff);
    rd_chk(8'h10, 32'h0);
    rd_chk(8'h04, 32'h0000_0009);
    wr_reg(8'h04, 32'h0000_0001);
    q(32'h2, 32'h0, {32'h1, 96'h0});
    rd_chk(8'h04, 32'h0000_0006);
    wr_reg(8'h04, 32'h0000_0002);
    rd_chk(8'h04, 32'h0000_0004);
    $display("register tests done");
    report_and_stop();
  end
endmodule : testbench
`default_nettype wire
